/* File: i2c_bridge_command_interface_bench.sv */
// Self-checking bench: host end and device end joined by icb_if
// Assumes 40 MHz ref_clk and the settings of icb_pkg
module i2c_bridge_command_interface_bench import icb_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_LEN = 2500;
  localparam int WAIT_MAX = 40000;
  logic       ref_clk = 1'b0;
  logic       nrst, a0, a1, force_busy, op_start, dev_reset;
  logic       busy_flag = 1'b0;
  logic       req_valid, req_ready, req_poll, req_read_only, done, nacked;
  logic [6:0] sflags, dev_addr;
  logic [7:0] rdata, op_code, op_param, config_byte, req_code, req_param;
  logic [7:0] rd_byte, seen_code, seen_param, m_cfg, prm;
  logic [31:0] seed;
  logic [7:0] bus_cmds [5];
  int         fail_count, tests_run, busy_cnt, ops_seen, resets_seen, n;

  icb_if link_if ();
  icb_dev icb_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link_if),
    .addr_select_pin_low(a0), .addr_select_pin_high(a1),
    .bus_busy_flag(busy_flag), .status_flags(sflags),
    .bus_read_data(rdata), .op_start(op_start), .op_code(op_code),
    .op_param(op_param), .dev_reset(dev_reset),
    .config_byte(config_byte));
  icb_host icb_host_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link_if),
    .dev_addr(dev_addr), .req_valid(req_valid), .req_ready(req_ready),
    .req_code(req_code), .req_param(req_param), .req_poll(req_poll),
    .req_read_only(req_read_only), .done(done), .nacked(nacked),
    .rd_byte(rd_byte));
  icb_chk icb_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .scl(link_if.scl),
    .sda(link_if.sda), .host_sda_o(link_if.host_sda_o),
    .host_sda_oe_n(link_if.host_sda_oe_n), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe_n(link_if.dev_sda_oe_n));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Downstream engine model: busy for a while after each op
  always @(negedge ref_clk) begin
    if (op_start === 1'b1) begin
      ops_seen++;
      seen_code = op_code;
      seen_param = op_param;
      busy_cnt = BUSY_LEN;
    end else if (busy_cnt > 0) begin
      busy_cnt--;
    end
    if (dev_reset === 1'b1) resets_seen++;
    busy_flag <= force_busy | (busy_cnt > 0);
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, input logic g);
    cmp8(nm, {7'h00, e}, {7'h00, g});
  endtask

  // Exhausted wait counts a mismatch and ends the run
  task automatic limit_chk(input int cnt, input int lim);
    if (cnt >= lim) begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic xfer(input logic [7:0] c, input logic [7:0] p,
                      input logic poll, input logic ro);
    @(negedge ref_clk);
    req_code = c;
    req_param = p;
    req_poll = poll;
    req_read_only = ro;
    req_valid = 1'b1;
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    limit_chk(n, 100);
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (n = 0; n < WAIT_MAX && done !== 1'b1; n++) @(negedge ref_clk);
    limit_chk(n, WAIT_MAX);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] e);
    xfer(8'h00, 8'h00, 1'b0, 1'b1);
    cmp1("read nack", 1'b0, nacked);
    cmp8(nm, e, rd_byte);
  endtask

  task automatic idle_wait();
    for (n = 0; n < WAIT_MAX && busy_flag !== 1'b0; n++) @(negedge ref_clk);
    limit_chk(n, WAIT_MAX);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    {a0, a1, force_busy, req_valid, req_poll, req_read_only} = 6'h00;
    {req_code, req_param} = 16'h0000;
    dev_addr = {ADDR_HI, 2'b00};
    seed = 32'd88;
    sflags = 7'(rnd());
    rdata = rnd();
    bus_cmds = '{bus_reset_presence_cmd, single_slot_cmd, bus_write_byte_cmd,
                 bus_read_byte_cmd, search_triplet_cmd};
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (5) @(negedge ref_clk);
    cmp8("cfg reset", CFG_RESET, config_byte);
    rd_chk("status", {sflags, 1'b0});
    m_cfg = rnd();
    xfer(write_config_cmd, m_cfg, 1'b0, 1'b0);
    cmp1("cfg nack", 1'b0, nacked);
    cmp8("cfg", m_cfg, config_byte);
    xfer(select_read_pointer_cmd, PTR_CONFIG, 1'b0, 1'b0);
    cmp1("ptr nack", 1'b0, nacked);
    rd_chk("cfg read", m_cfg);
    xfer(select_read_pointer_cmd, 8'he5, 1'b0, 1'b0);
    cmp1("bad ptr nack", 1'b1, nacked);
    rd_chk("ptr kept", m_cfg);
    xfer(select_read_pointer_cmd, PTR_DATA, 1'b0, 1'b0);
    cmp1("data ptr nack", 1'b0, nacked);
    rd_chk("data read", rdata);
    xfer(select_read_pointer_cmd, PTR_STATUS, 1'b0, 1'b0);
    rd_chk("status ptr", {sflags, 1'b0});
    force_busy = 1'b1;
    xfer(write_config_cmd, ~m_cfg, 1'b0, 1'b0);
    cmp1("busy cfg nack", 1'b1, nacked);
    cmp8("busy cfg", m_cfg, config_byte);
    xfer(bus_reset_presence_cmd, 8'h00, 1'b0, 1'b0);
    cmp1("busy rst nack", 1'b1, nacked);
    cmp8("busy ops", 8'h00, 8'(ops_seen));
    force_busy = 1'b0;
    idle_wait();
    xfer(full_device_reset_cmd, 8'h00, 1'b0, 1'b0);
    cmp1("reset nack", 1'b0, nacked);
    cmp8("resets", 8'h01, 8'(resets_seen));
    cmp8("cfg after reset", CFG_RESET, config_byte);
    rd_chk("status after reset", {sflags, 1'b0});
    for (int i = 0; i < 5; i++) begin
      prm = rnd();
      xfer(bus_cmds[i], prm, 1'b0, 1'b0);
      cmp1("op nack", 1'b0, nacked);
      cmp8("op count", 8'(i + 1), 8'(ops_seen));
      cmp8("op code", bus_cmds[i], seen_code);
      cmp8("op param", (i == 0 || i == 3) ? bus_cmds[i] : prm,
           seen_param);
      idle_wait();
    end
    rd_chk("status idle", {sflags, 1'b0});
    xfer(bus_reset_presence_cmd, 8'h00, 1'b1, 1'b0);
    cmp1("poll nack", 1'b0, nacked);
    cmp8("poll status", {sflags, 1'b0}, rd_byte);
    cmp8("poll ops", 8'h06, 8'(ops_seen));
    a1 = 1'b1;
    repeat (5) @(negedge ref_clk);
    xfer(8'h00, 8'h00, 1'b0, 1'b1);
    cmp1("addr mismatch", 1'b1, nacked);
    dev_addr = {ADDR_HI, 2'b10};
    rd_chk("addr match", {sflags, 1'b0});
    a0 = 1'b1;
    dev_addr = {ADDR_HI, 2'b11};
    repeat (5) @(negedge ref_clk);
    rd_chk("addr pins high", {sflags, 1'b0});
    give_verdict();
  end
endmodule // i2c_bridge_command_interface_bench

/* File: icb_chk.sv */
// Link checker for the command bridge two-wire link
// Assumes the signals of one icb_if, all on ref_clk
module icb_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last SCL fall, saturating
  logic [7:0] since_fall;
  logic [7:0] next_since_fall;
  logic       scl_q;
  wire        scl_fell = scl_q & ~scl;
  wire        cnt_full = (since_fall == 8'hff);
  assign next_since_fall = scl_fell ? 8'h00 :
                           cnt_full ? since_fall : since_fall + 8'h01;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      since_fall <= 8'hff;
      scl_q      <= 1'b1;
    end else begin
      since_fall <= next_since_fall;
      scl_q      <= scl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_dev_od;
    !dev_sda_oe_n |-> !dev_sda_o;
  endproperty
  property p_host_od;
    !host_sda_oe_n |-> !host_sda_o;
  endproperty
  property p_scl_high_min;
    $rose(scl) |-> scl [*3];
  endproperty
  property p_dev_lag;
    $fell(scl) |=> $stable(dev_sda_oe_n);
  endproperty
  property p_dev_window;
    $changed(dev_sda_oe_n) |-> since_fall <= 8'h06;
  endproperty
  property p_dev_scl_low;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  property p_no_clash;
    scl |-> (host_sda_oe_n | dev_sda_oe_n);
  endproperty
  property p_stop_free;
    (scl && $past(scl) && $rose(sda)) |-> dev_sda_oe_n;
  endproperty

  a_dev_od:       assert property (p_dev_od)
    else $error("device drives SDA high");
  a_host_od:      assert property (p_host_od)
    else $error("host drives SDA high");
  a_scl_high_min: assert property (p_scl_high_min)
    else $error("SCL high too short");
  a_dev_lag:      assert property (p_dev_lag)
    else $error("device SDA moved too soon after SCL fall");
  a_dev_window:   assert property (p_dev_window)
    else $error("device SDA moved late after SCL fall");
  a_dev_scl_low:  assert property (p_dev_scl_low)
    else $error("device SDA moved while SCL high");
  a_no_clash:     assert property (p_no_clash)
    else $error("both ends pull SDA while SCL high");
  a_stop_free:    assert property (p_stop_free)
    else $error("device holds SDA at STOP");

  c_ack:   cover property ($rose(scl) && !dev_sda_oe_n);
  c_stop:  cover property (scl && $past(scl) && $rose(sda));
  c_start: cover property (scl && $past(scl) && $fell(sda));
endmodule // icb_chk

/* File: icb_dev.sv */
// Bridge-side I2C slave command interpreter
// Assumes downstream engine reports busy and data on ref_clk
//
// Overview of operation
// RULE1 - Command F0h resets device, acknowledged
// RULE2 - Command E1h selects read pointer, one parameter
// RULE3 - Pointer C3h acknowledged, reads return configuration
// RULE4 - Invalid pointer like E5h refused, pointer kept
// RULE5 - Command D2h writes configuration, one parameter
// RULE6 - Command B4h starts downstream reset/presence cycle
// RULE7 - Command 87h starts single-bit time slot
// RULE8 - Command A5h writes one byte downstream
// RULE9 - Command 96h reads eight bits downstream
// RULE10 - Command 78h starts three-bit search triplet
// RULE11 - Write-configuration refused while bus busy
// RULE12 - Bus reset refused and not started while busy
// RULE13 - Master stops and restarts after any refusal
// RULE14 - Without polling master stops, waits, reads status
// RULE15 - Polling master reads status until busy clears
// RULE16 - Confirming read returns selected register byte
// RULE17 - SCL is input only, never stretched
// RULE18 - Ack valid codes, never extras or bad parameters
// RULE19 - Every read byte returns pointer-selected register
// RULE20 - Two pins set lowest two address bits
// RULE21 - Release SDA after master refuses read byte
module icb_dev import icb_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  icb_if.dev              link,
  input  wire logic       addr_select_pin_low,
  input  wire logic       addr_select_pin_high,
  input  wire logic       bus_busy_flag,
  input  wire logic [6:0] status_flags,
  input  wire logic [7:0] bus_read_data,
  output logic            op_start,
  output logic [7:0]      op_code,
  output logic [7:0]      op_param,
  output logic            dev_reset,
  output logic [7:0]      config_byte
);

  typedef enum logic [2:0] {
    DS_IDLE,
    DS_RX,
    DS_RX_ACK,
    DS_TX,
    DS_TX_ACK
  } icb_dstate_type;

  typedef enum logic [1:0] {
    PT_STATUS_SEL,
    PT_DATA_SEL,
    PT_CONFIG_SEL
  } icb_ptr_type;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Known command codes
  function automatic logic cmd_known(input logic [7:0] b);
    cmd_known = (b == full_device_reset_cmd) |   // RULE1
                (b == select_read_pointer_cmd) | // RULE2
                (b == write_config_cmd) |        // RULE5
                (b == bus_reset_presence_cmd) |  // RULE6
                (b == single_slot_cmd) |         // RULE7
                (b == bus_write_byte_cmd) |      // RULE8
                (b == bus_read_byte_cmd) |       // RULE9
                (b == search_triplet_cmd);       // RULE10
  endfunction

  // Commands accepted regardless of busy
  function automatic logic cmd_busy_ok(input logic [7:0] b);
    cmd_busy_ok = (b == full_device_reset_cmd) |
                  (b == select_read_pointer_cmd);
  endfunction

  // Valid pointer codes
  function automatic logic is_ptr(input logic [7:0] b);
    is_ptr = (b == PTR_STATUS) | (b == PTR_DATA) | (b == PTR_CONFIG);
  endfunction

  function automatic icb_ptr_type ptr_of(input logic [7:0] b);
    if (b == PTR_CONFIG) begin
      ptr_of = PT_CONFIG_SEL;  // RULE3
    end else if (b == PTR_DATA) begin
      ptr_of = PT_DATA_SEL;
    end else begin
      ptr_of = PT_STATUS_SEL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  icb_dstate_type st;
  icb_ptr_type    ptr;
  logic           scl_m;
  logic           scl_s;
  logic           scl_p;
  logic           sda_m;
  logic           sda_s;
  logic           sda_p;
  logic [1:0]     ad_m;
  logic [1:0]     ad_s;
  logic [3:0]     cnt;
  logic [7:0]     sh;
  logic [7:0]     pend;
  logic [1:0]     idx;
  logic           drive_low;
  logic           master_ack;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_m <= 1'h1;
      scl_s <= 1'h1;
      scl_p <= 1'h1;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
      sda_p <= 1'h1;
      ad_m  <= 2'h0;
      ad_s  <= 2'h0;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      ad_m  <= {addr_select_pin_high, addr_select_pin_low};
      ad_s  <= ad_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link events and byte decisions

  wire logic start_c  = scl_s & scl_p & sda_p & ~sda_s;
  wire logic stop_c   = scl_s & scl_p & ~sda_p & sda_s;
  wire logic scl_rise = scl_s & ~scl_p;
  wire logic scl_fall = ~scl_s & scl_p;
  wire logic byte_end = (st == DS_RX) & scl_fall & (cnt == BYTE_BITS);

  wire logic addr_hit = sh[7:1] == {ADDR_HI, ad_s};  // RULE20

  wire logic busy_block = bus_busy_flag & ~cmd_busy_ok(sh);  // RULE11 RULE12

  wire logic param_ok = cmd_has_param(pend) &  // RULE4
                        ((pend != select_read_pointer_cmd) | is_ptr(sh));

  wire logic ack_now = (idx == IDX_ADDR) ? addr_hit :
                       (idx == IDX_CMD)  ? cmd_known(sh) & ~busy_block :
                       (idx == IDX_PARAM) & param_ok;  // RULE18

  wire logic fire = byte_end & ack_now &
                    ((idx == IDX_PARAM) |
                     ((idx == IDX_CMD) & ~cmd_has_param(sh)));

  wire logic [7:0] fire_code = (idx == IDX_PARAM) ? pend : sh;

  wire logic go_tx = (idx == IDX_ADDR) & (sh[0] == RW_READ);

  wire logic [7:0] rd_sel =
    (ptr == PT_CONFIG_SEL) ? config_byte :
    (ptr == PT_DATA_SEL)   ? bus_read_data :
                             {status_flags, bus_busy_flag};  // RULE15 RULE16

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st         <= DS_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      pend       <= 8'h00;
      idx        <= IDX_ADDR;
      drive_low  <= 1'h0;
      master_ack <= 1'h0;
    end else if (start_c) begin
      st        <= DS_RX;
      cnt       <= 4'h0;
      idx       <= IDX_ADDR;
      drive_low <= 1'h0;
    end else if (stop_c) begin
      st        <= DS_IDLE;
      drive_low <= 1'h0;
    end else begin
      unique case (st)
        DS_IDLE: begin
        end
        DS_RX: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (byte_end) begin
            drive_low <= ack_now;  // RULE18
            st        <= ack_now ? DS_RX_ACK : DS_IDLE;
            if (idx == IDX_CMD) begin
              pend <= sh;
            end
          end
        end
        DS_RX_ACK: if (scl_fall) begin
          cnt       <= 4'h0;
          idx       <= (idx == IDX_EXTRA) ? idx : idx + 2'h1;
          sh        <= go_tx ? rd_sel : sh;
          drive_low <= go_tx & ~rd_sel[7];
          st        <= go_tx ? DS_TX : DS_RX;
        end
        DS_TX: if (scl_fall) begin
          cnt       <= cnt + 4'h1;
          sh        <= {sh[6:0], 1'h0};
          drive_low <= (cnt != LAST_BIT) & ~sh[6];
          st        <= (cnt == LAST_BIT) ? DS_TX_ACK : DS_TX;
        end
        DS_TX_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end
          if (scl_fall) begin
            sh        <= rd_sel;                    // RULE19
            cnt       <= 4'h0;
            drive_low <= master_ack & ~rd_sel[7];   // RULE21
            st        <= master_ack ? DS_TX : DS_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command effects

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr         <= PT_STATUS_SEL;
      config_byte <= CFG_RESET;
      op_start    <= 1'h0;
      op_code     <= 8'h00;
      op_param    <= 8'h00;
      dev_reset   <= 1'h0;
    end else begin
      op_start  <= fire & ~cmd_busy_ok(fire_code) &
                   (fire_code != write_config_cmd);  // RULE6 RULE12
      dev_reset <= fire & (fire_code == full_device_reset_cmd);  // RULE1
      if (fire) begin
        case (fire_code)
          full_device_reset_cmd: begin
            ptr         <= PT_STATUS_SEL;
            config_byte <= CFG_RESET;
          end
          select_read_pointer_cmd: begin
            ptr <= ptr_of(sh);  // RULE2 RULE3
          end
          write_config_cmd: begin
            ptr         <= PT_CONFIG_SEL;
            config_byte <= sh;  // RULE5
          end
          default: begin
            ptr      <= PT_STATUS_SEL;
            op_code  <= fire_code;
            op_param <= sh;  // RULE7 RULE8 RULE9 RULE10
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain SDA only; no SCL driver exists

  assign link.dev_sda_o    = 1'h0;
  assign link.dev_sda_oe_n = ~drive_low;  // RULE17

endmodule // icb_dev

/* File: icb_host.sv */
// Command master end of the two-wire link
// Assumes one request at a time, taken when req_ready is high
module icb_host import icb_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  icb_if.host             link,
  input  wire logic [6:0] dev_addr,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [7:0] req_code,
  input  wire logic [7:0] req_param,
  input  wire logic       req_poll,
  input  wire logic       req_read_only,
  output logic            done,
  output logic            nacked,
  output logic [7:0]      rd_byte
);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_START,
    HS_BYTE,
    HS_STOP
  } icb_hstate_type;

  typedef enum logic [2:0] {
    HB_ADDRW,
    HB_CMD,
    HB_PARAM,
    HB_ADDRR,
    HB_READ
  } icb_hbyte_type;

  // Byte plus released ack slot
  function automatic logic [8:0] frame(input logic [7:0] b);
    frame = {b, 1'h1};
  endfunction

  icb_hstate_type st;
  icb_hbyte_type  what;
  logic [7:0]     div;
  logic [1:0]     ph;
  logic [3:0]     cnt;
  logic [8:0]     sh;
  logic [7:0]     rx;
  logic [7:0]     code_q;
  logic [7:0]     param_q;
  logic           poll_q;
  logic           ack_s;
  logic           scl_q;
  logic           drive_low;
  logic           sda_m;
  logic           sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  wire logic tick    = (st != HS_IDLE) & (div == QTR_LAST);
  wire logic reading = what == HB_READ;
  wire logic ack_bit = cnt == BYTE_BITS;
  wire logic more    = poll_q & rx[0];  // RULE15
  wire logic out_bit = (reading & ack_bit) ? ~more : sh[8];
  wire logic [8:0] raddr_frame = frame({dev_addr, RW_READ});

  assign req_ready = st == HS_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-period divider and SDA synchroniser

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div   <= 8'h00;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
    end else begin
      div   <= (st == HS_IDLE || div == QTR_LAST) ? 8'h00 : div + 8'h01;
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st        <= HS_IDLE;
      what      <= HB_ADDRW;
      ph        <= PH_SETUP;
      cnt       <= 4'h0;
      sh        <= 9'h1ff;
      rx        <= 8'h00;
      code_q    <= 8'h00;
      param_q   <= 8'h00;
      poll_q    <= 1'h0;
      ack_s     <= 1'h1;
      scl_q     <= 1'h1;
      drive_low <= 1'h0;
      done      <= 1'h0;
      nacked    <= 1'h0;
      rd_byte   <= 8'h00;
    end else begin
      done <= 1'h0;
      if (st == HS_IDLE) begin
        if (req_valid) begin
          st      <= HS_START;
          ph      <= PH_SETUP;
          nacked  <= 1'h0;
          code_q  <= req_code;
          param_q <= req_param;
          poll_q  <= req_poll & ~req_read_only;
          what    <= req_read_only ? HB_ADDRR : HB_ADDRW;  // RULE16
          sh      <= frame({dev_addr, req_read_only});
        end
      end else if (tick) begin
        ph <= ph + 2'h1;
        unique case (st)
          HS_START: begin
            unique case (ph)
              PH_SETUP: drive_low <= 1'h0;
              PH_RISE:  scl_q <= 1'h1;
              PH_HIGH:  drive_low <= 1'h1;
              PH_FALL: begin
                scl_q <= 1'h0;
                cnt   <= 4'h0;
                st    <= HS_BYTE;
              end
            endcase
          end
          HS_BYTE: begin
            unique case (ph)
              PH_SETUP: drive_low <= ~out_bit;
              PH_RISE:  scl_q <= 1'h1;
              PH_HIGH: begin
                if (ack_bit) begin
                  ack_s <= sda_s;
                end else begin
                  rx <= {rx[6:0], sda_s};
                end
              end
              PH_FALL: begin
                scl_q <= 1'h0;
                cnt   <= ack_bit ? 4'h0 : cnt + 4'h1;
                sh    <= {sh[7:0], 1'h1};
                if (ack_bit) begin
                  if (!reading && ack_s) begin
                    nacked <= 1'h1;
                    st     <= HS_STOP;  // RULE13
                  end else begin
                    unique case (what)
                      HB_ADDRW: begin
                        what <= HB_CMD;
                        sh   <= frame(code_q);
                      end
                      HB_CMD, HB_PARAM: begin
                        if (what == HB_CMD && cmd_has_param(code_q)) begin
                          what <= HB_PARAM;
                          sh   <= frame(param_q);
                        end else begin
                          what <= HB_ADDRR;
                          sh   <= raddr_frame;
                          st   <= poll_q ? HS_START : HS_STOP;  // RULE14
                        end
                      end
                      HB_ADDRR: begin
                        what <= HB_READ;
                        sh   <= frame(RX_FILL);
                      end
                      HB_READ: begin
                        rd_byte <= rx;
                        sh      <= frame(RX_FILL);
                        st      <= more ? HS_BYTE : HS_STOP;  // RULE15
                      end
                      default: st <= HS_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          HS_STOP: begin
            unique case (ph)
              PH_SETUP: drive_low <= 1'h1;
              PH_RISE:  scl_q <= 1'h1;
              PH_HIGH:  drive_low <= 1'h0;
              PH_FALL: begin
                st   <= HS_IDLE;
                done <= 1'h1;
              end
            endcase
          end
          default: st <= HS_IDLE;
        endcase
      end
    end
  end

  assign link.scl           = scl_q;
  assign link.host_sda_o    = 1'h0;
  assign link.host_sda_oe_n = ~drive_low;

endmodule // icb_host

/* File: icb_if.sv */
// Two-wire link between command master and bridge front end
// Assumes open-drain SDA with pull-up, SCL driven by master only
interface icb_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // Wired-AND with pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe_n,
    input  sda
  );
endinterface

/* File: icb_pkg.sv */
// Shared constants for the I2C command bridge front end
// Assumes both ends run from one 40 MHz ref_clk
package icb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Slave address and command codes
  localparam logic [4:0] ADDR_HI                 = 5'h06;
  localparam logic       RW_WRITE                = 1'h0;
  localparam logic       RW_READ                 = 1'h1;
  localparam logic [7:0] full_device_reset_cmd   = 8'hf0;
  localparam logic [7:0] select_read_pointer_cmd = 8'he1;
  localparam logic [7:0] write_config_cmd        = 8'hd2;
  localparam logic [7:0] bus_reset_presence_cmd  = 8'hb4;
  localparam logic [7:0] single_slot_cmd         = 8'h87;
  localparam logic [7:0] bus_write_byte_cmd      = 8'ha5;
  localparam logic [7:0] bus_read_byte_cmd       = 8'h96;
  localparam logic [7:0] search_triplet_cmd      = 8'h78;

  ////////////////////////////////////////////////////////////////////////////
  // Read pointer codes and reset values
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_DATA   = 8'he1;
  localparam logic [7:0] PTR_CONFIG = 8'hc3;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] RX_FILL    = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte counting
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [1:0] IDX_ADDR  = 2'h0;
  localparam logic [1:0] IDX_CMD   = 2'h1;
  localparam logic [1:0] IDX_PARAM = 2'h2;
  localparam logic [1:0] IDX_EXTRA = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing, four phases per SCL period
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         SCL_PERIOD_NS = 10_000;
  localparam int         QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;

  // Commands followed by one parameter byte
  function automatic logic cmd_has_param(input logic [7:0] b);
    cmd_has_param = (b == select_read_pointer_cmd) |
                    (b == write_config_cmd) | (b == single_slot_cmd) |
                    (b == bus_write_byte_cmd) | (b == search_triplet_cmd);
  endfunction

endpackage
